// ===== fcb_map.svh
`ifndef FCB_MAP_SVH
`define FCB_MAP_SVH

// ****************************************************************
// Condition select codes
// ****************************************************************
`define FCB_COND_W 3
`define FCB_COND_SIGNED_GE 3'h0
`define FCB_COND_SIGNED_LESS 3'h1
`define FCB_COND_HALF_SET 3'h2
`define FCB_COND_HALF_CLEAR 3'h3
`define FCB_COND_NONNEG 3'h4

// ****************************************************************
// Status flag bit positions in the flag vector
// ****************************************************************
`define FCB_FLAG_W 8
`define FCB_FLAG_V 3
`define FCB_FLAG_N 2
`define FCB_FLAG_H 5

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define FCB_PTR_W 16
`define FCB_OFS_W 7
`define FCB_PTR_RST 16'h0000

`endif

// ===== fcb_pkg.sv
package fcb_pkg;
  // Sequencer states of the branch unit.
  typedef enum logic [1:0] {
    FCB_IDLE = 2'b00,
    FCB_TAKE = 2'b01
  } fcb_state_e;
endpackage

// ===== fcb_branch.sv
// Operation
// - Signed ge: jump when N xor V is 0.
// - Signed less: jump when N xor V is 1.
// - Half carry set: jump when H is 1.
// - Half carry clear: jump when H is 0.
// - Nonnegative: jump when N is 0; flags untouched.
`timescale 1ns/1ps
`include "fcb_map.svh"

module fcb_branch
  import fcb_pkg::*;
#(
  parameter int PTR_W = `FCB_PTR_W,
  parameter int OFS_W = `FCB_OFS_W
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [`FCB_COND_W-1:0] cond_sel,
  input wire logic [OFS_W-1:0] offset,
  input wire logic [`FCB_FLAG_W-1:0] status_flags,
  output logic busy,
  output logic done,
  output logic taken,
  output logic [PTR_W-1:0] instr_pointer
);

  // ****************************************************************
  // State
  // ****************************************************************
  // Everything the unit remembers. The target is kept apart from the
  // pointer so a refused start cannot disturb a jump in flight.
  typedef struct packed {
    fcb_state_e st;
    logic [PTR_W-1:0] ip;
    logic [PTR_W-1:0] target;
    logic done;
    logic taken;
  } fcb_regs_s;

  fcb_regs_s r_q;
  fcb_regs_s r_d;

  // Shared decode of the selected flag test. Codes with no test fall
  // through, so a corrupted select never moves the pointer far.
  function automatic logic cond_true(input logic [2:0] sel,
                                     input logic [`FCB_FLAG_W-1:0] f);
    logic sv;
    sv = f[`FCB_FLAG_N] ^ f[`FCB_FLAG_V];
    cond_true = 1'b0;
    case (sel)
      `FCB_COND_SIGNED_GE: cond_true = ~sv;
      `FCB_COND_SIGNED_LESS: cond_true = sv;
      `FCB_COND_HALF_SET: cond_true = f[`FCB_FLAG_H];
      `FCB_COND_HALF_CLEAR: cond_true = ~f[`FCB_FLAG_H];
      `FCB_COND_NONNEG: cond_true = ~f[`FCB_FLAG_N];
      default: cond_true = 1'b0;
    endcase
  endfunction

  // Condition, sign-extended offset and the plain step to the next word.
  logic hit;
  logic [PTR_W-1:0] ofs_ext;
  logic [PTR_W-1:0] next_ip;

  // Offset is sign-extended so backward jumps wrap correctly.
  assign ofs_ext = PTR_W'($signed(offset));
  assign next_ip = r_q.ip + PTR_W'(1);
  assign hit = cond_true(cond_sel, status_flags);

  // ****************************************************************
  // Next state
  // ****************************************************************
  // A taken jump spends a second cycle so the target adder output is
  // registered before the pointer moves; this keeps the path short.
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    unique case (r_q.st)
      FCB_IDLE: begin
        if (start) begin
          if (hit) begin
            r_d.target = next_ip + ofs_ext;
            r_d.st = FCB_TAKE;
          end else begin
            r_d.ip = next_ip;
            r_d.done = 1'b1;
            r_d.taken = 1'b0;
          end
        end
      end
      FCB_TAKE: begin
        // A start seen in this cycle is refused without notice; the
        // caller must wait for done before asking again.
        r_d.ip = r_q.target;
        r_d.done = 1'b1;
        r_d.taken = 1'b1;
        r_d.st = FCB_IDLE;
      end
    endcase
  end

  // Register the whole state in one place.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r_q.st <= FCB_IDLE;
      r_q.ip <= PTR_W'(`FCB_PTR_RST);
      r_q.target <= PTR_W'(`FCB_PTR_RST);
      r_q.done <= 1'b0;
      r_q.taken <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // Flags are only read here, never driven, so no flag can change.
  assign busy = (r_q.st == FCB_TAKE);
  assign done = r_q.done;
  assign taken = r_q.taken;
  assign instr_pointer = r_q.ip;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Each flag test against its rule, one outcome per assertion.
  a_ge_jump: assert property (
    start && !busy && cond_sel == `FCB_COND_SIGNED_GE &&
    !(status_flags[`FCB_FLAG_N] ^ status_flags[`FCB_FLAG_V])
    |=> busy ##1 (instr_pointer ==
      $past(instr_pointer, 2) + PTR_W'(1) + $past(ofs_ext, 2)))
    else $error("signed ge jump target wrong");
  a_lt_fall: assert property (
    start && !busy && cond_sel == `FCB_COND_SIGNED_LESS &&
    !(status_flags[`FCB_FLAG_N] ^ status_flags[`FCB_FLAG_V])
    |=> done && !taken && instr_pointer == $past(instr_pointer) + PTR_W'(1))
    else $error("signed less fell through wrongly");
  a_hset_take: assert property (
    start && !busy && cond_sel == `FCB_COND_HALF_SET &&
    status_flags[`FCB_FLAG_H] |=> busy ##1 (done && taken))
    else $error("half carry set not taken");
  a_hclr_skip: assert property (
    start && !busy && cond_sel == `FCB_COND_HALF_CLEAR &&
    status_flags[`FCB_FLAG_H] |=> done && !taken)
    else $error("half carry clear wrongly taken");
  a_nonneg_jump: assert property (
    start && !busy && cond_sel == `FCB_COND_NONNEG &&
    !status_flags[`FCB_FLAG_N] |=> busy)
    else $error("nonnegative branch not taken");
  a_two_cycle: assert property (
    busy |=> !busy && done && taken)
    else $error("taken branch not two cycles");
  a_ip_stable: assert property (
    !done |-> $stable(instr_pointer))
    else $error("pointer moved without completion");
  a_idle_quiet: assert property (
    !start && !busy |=> !done)
    else $error("completion without request");

  // ****************************************************************
  // Opposite outcomes, refusal and timing
  // ****************************************************************
  // The other outcome of each flag test, so a test stuck on jumping or
  // stuck on falling through cannot slip past.
  a_ge_fall: assert property (
    start && !busy && cond_sel == `FCB_COND_SIGNED_GE &&
    (status_flags[`FCB_FLAG_N] ^ status_flags[`FCB_FLAG_V])
    |=> done && !taken && instr_pointer == $past(instr_pointer) + PTR_W'(1))
    else $error("signed ge jumped on a failed compare");
  a_lt_jump: assert property (
    start && !busy && cond_sel == `FCB_COND_SIGNED_LESS &&
    (status_flags[`FCB_FLAG_N] ^ status_flags[`FCB_FLAG_V])
    |=> busy ##1 (done && taken && instr_pointer ==
      $past(instr_pointer, 2) + PTR_W'(1) + $past(ofs_ext, 2)))
    else $error("signed less jump target wrong");
  a_hset_skip: assert property (
    start && !busy && cond_sel == `FCB_COND_HALF_SET &&
    !status_flags[`FCB_FLAG_H] |=> done && !taken)
    else $error("half carry set wrongly taken");
  a_hclr_take: assert property (
    start && !busy && cond_sel == `FCB_COND_HALF_CLEAR &&
    !status_flags[`FCB_FLAG_H] |=> busy ##1 (done && taken &&
      instr_pointer == $past(instr_pointer, 2) + PTR_W'(1) +
      $past(ofs_ext, 2)))
    else $error("half carry clear jump target wrong");
  a_nonneg_fall: assert property (
    start && !busy && cond_sel == `FCB_COND_NONNEG &&
    status_flags[`FCB_FLAG_N] |=> done && !taken)
    else $error("nonnegative branch taken on negative");

  // Codes beyond the five tests must never jump.
  a_odd_code: assert property (
    start && !busy && cond_sel > `FCB_COND_NONNEG
    |=> done && !taken && instr_pointer == $past(instr_pointer) + PTR_W'(1))
    else $error("unused condition code jumped");

  // Whatever the test, a false one completes next cycle one word on.
  a_fall_step: assert property (
    start && !busy && !hit
    |=> done && !taken && instr_pointer == $past(instr_pointer) + PTR_W'(1))
    else $error("fall through not one cycle");

  // A true test holds busy one cycle and lands on the signed target.
  a_take_step: assert property (
    start && !busy && hit |=> busy ##1 (done && taken &&
      instr_pointer == $past(instr_pointer, 2) + PTR_W'(1) +
      $past(ofs_ext, 2)))
    else $error("taken jump not two cycles");

  // A start in the busy cycle is dropped: the stored target still lands.
  a_busy_refuse: assert property (
    busy && start |=> !busy && instr_pointer == $past(r_q.target))
    else $error("start accepted while busy");

  // The outcome flag only moves together with a completion pulse.
  a_taken_hold: assert property (
    !done |-> $stable(taken))
    else $error("taken moved without completion");

  // ****************************************************************
  // Coverage of the main scenarios
  // ****************************************************************
  // A backward jump and a start refused in the busy cycle are the two
  // cases a directed test most easily misses.
  c_taken: cover property (start && !busy ##1 busy ##1 taken);
  c_fall: cover property (start && !busy ##1 done && !taken);
  c_back: cover property (start && !busy && hit && offset[OFS_W-1]
    ##2 done && taken);
  c_b2b: cover property (done ##0 start && !busy);
  c_refused: cover property (busy && start);

endmodule

// ===== test_flag_conditional_branch.sv
`timescale 1ns/1ps
`include "fcb_map.svh"

module test_flag_conditional_branch;
  // ****************************************************************
  // Stimulus, clock and checking helpers
  // ****************************************************************
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic [2:0] cond_sel = 3'h0;
  logic [6:0] offset = 7'h00;
  logic [7:0] status_flags = 8'h00;
  logic busy, done, taken;
  logic [15:0] instr_pointer, exp_ptr;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  fcb_branch i_dut (.mclk(mclk), .nrst(nrst), .start(start),
    .cond_sel(cond_sel), .offset(offset), .status_flags(status_flags),
    .busy(busy), .done(done), .taken(taken),
    .instr_pointer(instr_pointer));

  // Clock toggles every half period of 2 ns.
  always #2 mclk = ~mclk;

  // A hang is cut short long after the 43 or so cycles needed.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      num_errors++;
      close_out();
    end
  end

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Unused flag bits are set so a wrong bit position gives a wrong jump.
  function logic [7:0] fl(input logic n, input logic v, input logic h);
    fl = 8'hD3 | {2'h0, h, 1'b0, v, n, 2'h0};
  endfunction

  // One branch. Entered just after an edge, so a new start may meet a
  // done pulse. A taken jump drops start and flips the flags so a late
  // read shows; a fall-through leaves start up for the next call.
  task branch(input logic [2:0] c, input logic [6:0] k,
              input logic [7:0] f, input logic jump);
    int n;
    logic [15:0] want;
    want = exp_ptr + 16'h0001 + (jump ? {{9{k[6]}}, k} : 16'h0000);
    cond_sel = c;
    offset = k;
    status_flags = f;
    start = 1'b1;
    @(posedge mclk);
    #1 n = 1;
    if (jump) begin
      start = 1'b0;
      status_flags = ~f;
    end
    check(16'(busy), 16'(jump));
    while (done !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1 n++;
    end
    check(16'(n), jump ? 16'h0002 : 16'h0001);
    check(16'(taken), 16'(jump));
    check(instr_pointer, want);
    exp_ptr = want;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_signed;
    logic n, v;
    for (int i = 0; i < 4; i++) begin
      {v, n} = i[1:0];
      branch(`FCB_COND_SIGNED_GE, 7'h3F, fl(n, v, i[0]), !(n ^ v));
      branch(`FCB_COND_SIGNED_LESS, 7'h40, fl(n, v, i[1]), n ^ v);
    end
    $display("signed test done");
  endtask

  task t_half;
    for (int i = 0; i < 4; i++) begin
      branch(`FCB_COND_HALF_SET, 7'h7F, fl(i[1], i[0], i[0]), i[0]);
      branch(`FCB_COND_HALF_CLEAR, 7'h01, fl(i[1], 1'b0, i[0]), !i[0]);
    end
    $display("half carry test done");
  endtask

  task t_nonneg;
    for (int i = 0; i < 3; i++) begin
      branch(`FCB_COND_NONNEG, 7'h20, fl(i[0], i[1], 1'b0), !i[0]);
      branch(3'(5 + i), 7'h3F, fl(1'b0, 1'b0, 1'b1), 1'b0);
    end
    $display("nonnegative test done");
  endtask

  // A start held through the busy cycle is refused, done lasts one
  // cycle, and a reset once the unit is idle again clears every output at once.
  task t_refuse_reset;
    logic [15:0] want;
    want = exp_ptr + 16'h0006;
    cond_sel = `FCB_COND_HALF_SET;
    offset = 7'h05;
    status_flags = fl(1'b0, 1'b0, 1'b1);
    start = 1'b1;
    @(posedge mclk);
    #1 cond_sel = `FCB_COND_HALF_CLEAR;
    check(16'(busy), 16'h0001);
    @(posedge mclk);
    #1 start = 1'b0;
    check(16'(done & taken), 16'h0001);
    check(instr_pointer, want);
    @(posedge mclk);
    #1 check(16'(done), 16'h0000);
    check(instr_pointer, want);
    nrst = 1'b0;
    #1 check({13'h0000, busy, done, taken}, 16'h0000);
    check(instr_pointer, 16'h0000);
    repeat (3) @(posedge mclk);
    #1 nrst = 1'b1;
    check(instr_pointer, 16'h0000);
    exp_ptr = 16'h0000;
    branch(`FCB_COND_SIGNED_GE, 7'h7E, fl(1'b1, 1'b1, 1'b0), 1'b1);
    $display("refusal and reset test done");
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    #1 nrst = 1'b1;
    exp_ptr = 16'h0000;
    t_signed();
    t_half();
    t_nonneg();
    t_refuse_reset();
    close_out();
  end
endmodule
